// *** design/two_wire_slave_pkg.sv ***
package two_wire_slave_pkg;

  // register indices on the plain register port
  localparam int         REG_ADDR_W  = 3;
  localparam logic [2:0] REG_CTRL_A  = 3'h0;
  localparam logic [2:0] REG_CTRL_B  = 3'h1;
  localparam logic [2:0] REG_STATUS  = 3'h2;
  localparam logic [2:0] REG_OWN     = 3'h3;
  localparam logic [2:0] REG_DATA    = 3'h4;
  localparam logic [2:0] REG_MASK    = 3'h5;
  localparam logic [2:0] REG_IRQ_EN  = 3'h6;

  // slave_control_a fields
  localparam int CA_SMART    = 0;
  localparam int CA_PROM     = 1;
  localparam int CA_STOP_IE  = 2;
  localparam int CA_ENABLE   = 3;

  // slave_control_b fields
  localparam int CB_CMD_LSB  = 0;
  localparam int CB_CMD_MSB  = 1;
  localparam int CB_ACK      = 2;

  // status fields; the interrupt enable register shares bits 7 and 6
  localparam int ST_CAUSE    = 0;
  localparam int ST_DIR      = 1;
  localparam int ST_RACK     = 4;
  localparam int ST_HOLD     = 5;
  localparam int ST_AFLAG    = 6;
  localparam int ST_DFLAG    = 7;

  // mask_or_second_addr bit 0
  localparam int MK_SECOND   = 0;

  localparam logic [7:0] OWN_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  typedef enum logic [6:0] {
    S_IDLE   = 7'b000_0001,
    S_ADDR   = 7'b000_0010,
    S_HOLD   = 7'b000_0100,
    S_ACK    = 7'b000_1000,
    S_RX     = 7'b001_0000,
    S_TX     = 7'b010_0000,
    S_TX_ACK = 7'b100_0000
  } slave_state_type;

endpackage

// *** design/two_wire_slave_addr_data.sv ***
`timescale 1ns/1ps
// Summary of operation
// - direction bit holds last address read/write bit
// - cause bit: zero stop, one address
// - address compared with own address bits 7:1
// - own address bit 0 enables general call
// - ten-bit: hardware matches first byte only
// - address match sets flag, updates direction
// - promiscuous mode matches every address
// - data register blocked unless clock held
// - master read: shift out, take ack, flag
// - master write: full byte sets data flag
// - smart mode: data read triggers acknowledge action
// - data access clears both flags and hold
// - mask bits force matching address bits
// - second-address enable matches two addresses
// - second-address enable is zero after reset
// - flags hold SCL low until cleared, stop flag excepted
// - acknowledge action zero ACK, one NACK
module two_wire_slave_addr_data
  import two_wire_slave_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // bus pins, open drain
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // interrupt
  output logic                       irq
);

  typedef struct packed {
    slave_state_type state;
    logic [7:0]      shift;
    logic [3:0]      cnt;
    logic [7:0]      data;
    logic [7:0]      own;
    logic [7:0]      mask;
    logic            enable;
    logic            stop_ie;
    logic            prom;
    logic            smart;
    logic            ack_action;
    logic            data_flag;
    logic            addr_stop_flag;
    logic            flag_cause;
    logic            direction_status;
    logic            recv_ack;
    logic [1:0]      irq_en;
    logic            need_ack;
    logic            after_addr;
    logic            nack;
    logic            fin;
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_p;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_p;
    logic            scl_oe;
    logic            sda_oe;
    logic [7:0]      rdata;
    logic            irq;
  } slave_reg_type;

  // synchronisers start at the idle bus level so no false edge follows reset
  localparam slave_reg_type RESET_VALUE = '{
    state: S_IDLE, own: OWN_RESET, mask: MASK_RESET,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, default: '0};

  slave_reg_type st;
  slave_reg_type next_st;

  logic data_access;
  logic access_ok;
  logic release_ev;
  logic finish;
  logic scl_rise;
  logic scl_fall;
  logic ev_start;
  logic ev_stop;
  logic ev_eval;
  logic ev_rxdone;

  function automatic logic addr_match(input logic [6:0] a,
                                      input logic [7:0] own,
                                      input logic [7:0] mask,
                                      input logic       prom);
    logic gc;
    logic hit;
    gc  = own[0] && (a == 7'h00);
    // ten-bit headers 11110nn compare like any first byte
    if (mask[MK_SECOND])
      hit = (a == own[7:1]) || (a == mask[7:1]);
    else
      hit = ((a ^ own[7:1]) & ~mask[7:1]) == 7'h00;
    return prom || gc || hit;
  endfunction

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_p  = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_p  = st.sda_s2;
    scl_rise = st.scl_s2 && !st.scl_p;
    scl_fall = !st.scl_s2 && st.scl_p;
    ev_start = st.scl_s2 && st.scl_p && st.sda_p && !st.sda_s2;
    ev_stop  = st.scl_s2 && st.scl_p && !st.sda_p && st.sda_s2;
    ev_eval   = 1'b0;
    ev_rxdone = 1'b0;
    release_ev = 1'b0;
    finish     = 1'b0;
    data_access = (reg_rd || reg_wr) && (reg_addr == REG_DATA);
    access_ok   = data_access && st.scl_oe;

    next_st.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL_A: next_st.rdata = {4'h0, st.enable, st.stop_ie,
                                     st.prom, st.smart};
        REG_CTRL_B: next_st.rdata = {5'h00, st.ack_action, 2'h0};
        REG_STATUS: next_st.rdata = {st.data_flag, st.addr_stop_flag,
                                     st.scl_oe, st.recv_ack, 2'h0,
                                     st.direction_status, st.flag_cause};
        REG_OWN:    next_st.rdata = st.own;
        REG_DATA:   next_st.rdata = access_ok ? st.data : 8'h00;
        REG_MASK:   next_st.rdata = st.mask;
        REG_IRQ_EN: next_st.rdata = {st.irq_en, 6'h00};
        default:    next_st.rdata = 8'h00;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL_A: begin
          next_st.smart   = reg_wdata[CA_SMART];
          next_st.prom    = reg_wdata[CA_PROM];
          next_st.stop_ie = reg_wdata[CA_STOP_IE];
          next_st.enable  = reg_wdata[CA_ENABLE];
        end
        REG_CTRL_B: begin
          next_st.ack_action = reg_wdata[CB_ACK];
          if (reg_wdata[CB_CMD_MSB]) begin
            release_ev = 1'b1;
            finish     = !reg_wdata[CB_CMD_LSB];
          end
        end
        REG_STATUS: begin
          if (reg_wdata[ST_DFLAG])
            next_st.data_flag = 1'b0;
          if (reg_wdata[ST_AFLAG])
            next_st.addr_stop_flag = 1'b0;
          // clearing a flag while held also lets the bus move on
          if (st.scl_oe && (reg_wdata[ST_DFLAG] || reg_wdata[ST_AFLAG]))
            release_ev = 1'b1;
        end
        REG_OWN:    next_st.own = reg_wdata;
        REG_DATA:   if (access_ok) next_st.data = reg_wdata;
        REG_MASK:   next_st.mask = reg_wdata;
        REG_IRQ_EN: next_st.irq_en = reg_wdata[7:6];
        default:    ;
      endcase
    end

    // a read without smart mode only frees the flags; a command follows
    if (access_ok && (reg_wr || st.smart))
      release_ev = 1'b1;
    if (access_ok || release_ev) begin
      next_st.data_flag      = 1'b0;
      next_st.addr_stop_flag = 1'b0;
    end

    case (st.state)
      S_IDLE: ;
      S_ADDR, S_RX: begin
        if (scl_rise) begin
          next_st.shift = {st.shift[6:0], st.sda_s2};
          next_st.cnt   = st.cnt + 4'h1;
        end
        if (scl_fall && st.cnt == BYTE_BITS) begin
          next_st.need_ack = 1'b1;
          next_st.state    = S_HOLD;
          if (st.state == S_RX) begin
            ev_rxdone          = 1'b1;
            next_st.data       = st.shift;
            next_st.data_flag  = 1'b1;
            next_st.after_addr = 1'b0;
          end else begin
            ev_eval = 1'b1;
            if (addr_match(st.shift[7:1], st.own, st.mask, st.prom)) begin
              next_st.addr_stop_flag   = 1'b1;
              next_st.flag_cause       = 1'b1;
              next_st.direction_status = st.shift[0];
              next_st.after_addr       = 1'b1;
            end else begin
              next_st.state = S_IDLE;
            end
          end
        end
      end
      S_HOLD: begin
        if (release_ev) begin
          next_st.cnt = 4'h0;
          if (st.need_ack) begin
            if (finish && st.direction_status) begin
              next_st.state = S_IDLE;
            end else begin
              // a new acknowledge action written with the command wins
              next_st.state  = S_ACK;
              next_st.nack   = next_st.ack_action;
              next_st.sda_oe = !next_st.ack_action;
              next_st.fin    = finish;
            end
          end else if (finish || st.recv_ack) begin
            next_st.state = S_IDLE;
          end else begin
            next_st.state  = S_TX;
            next_st.shift  = next_st.data;
            next_st.sda_oe = !next_st.data[7];
          end
        end
      end
      S_ACK: begin
        if (scl_rise)
          next_st.cnt = 4'h1;
        if (scl_fall && st.cnt != 4'h0) begin
          next_st.sda_oe = 1'b0;
          next_st.cnt    = 4'h0;
          if (st.nack || st.fin) begin
            next_st.state = S_IDLE;
          end else if (st.after_addr && st.direction_status) begin
            next_st.data_flag = 1'b1;
            next_st.need_ack  = 1'b0;
            next_st.state     = S_HOLD;
          end else begin
            next_st.state = S_RX;
          end
        end
      end
      S_TX: begin
        if (scl_rise)
          next_st.cnt = st.cnt + 4'h1;
        if (scl_fall) begin
          if (st.cnt == BYTE_BITS) begin
            next_st.sda_oe = 1'b0;
            next_st.cnt    = 4'h0;
            next_st.state  = S_TX_ACK;
          end else begin
            next_st.shift  = {st.shift[6:0], 1'b0};
            next_st.sda_oe = !st.shift[6];
          end
        end
      end
      S_TX_ACK: begin
        if (scl_rise) begin
          next_st.recv_ack = st.sda_s2;
          next_st.cnt      = 4'h1;
        end
        if (scl_fall && st.cnt != 4'h0) begin
          next_st.data_flag = 1'b1;
          next_st.need_ack  = 1'b0;
          next_st.state     = S_HOLD;
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    if (ev_start) begin
      next_st.state  = S_ADDR;
      next_st.cnt    = 4'h0;
      next_st.sda_oe = 1'b0;
    end else if (ev_stop) begin
      next_st.state  = S_IDLE;
      next_st.sda_oe = 1'b0;
      if (st.stop_ie) begin
        next_st.addr_stop_flag = 1'b1;
        next_st.flag_cause     = 1'b0;
      end
    end
    if (!st.enable) begin
      next_st.state  = S_IDLE;
      next_st.sda_oe = 1'b0;
    end
    // a stop flag does not stretch: the bus is already idle
    next_st.scl_oe = (next_st.data_flag || next_st.addr_stop_flag) &&
                     next_st.state != S_IDLE;
    next_st.irq = |({next_st.data_flag, next_st.addr_stop_flag} &
                    next_st.irq_en);
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      st <= RESET_VALUE;
    else
      st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = st.scl_oe;
  assign sda_oe    = st.sda_oe;
  assign irq       = st.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_DIR_LATCH: assert property (
    ev_eval && next_st.state == S_HOLD |=>
      st.direction_status == $past(st.shift[0]) && st.flag_cause)
    else $error("direction not taken from address byte");

  AST_STOP_CAUSE: assert property (
    ev_stop && st.stop_ie && st.enable |=>
      st.addr_stop_flag && !st.flag_cause)
    else $error("stop did not set flag with cause zero");

  AST_PROM_ALL: assert property (
    ev_eval && st.prom && !ev_start && !ev_stop |=>
      st.addr_stop_flag && st.state == S_HOLD)
    else $error("promiscuous mode missed an address");

  AST_NO_MATCH: assert property (
    ev_eval && !st.prom && !st.own[0] && !st.mask[MK_SECOND] &&
    (((st.shift[7:1] ^ st.own[7:1]) & ~st.mask[7:1]) != 7'h00) &&
    !ev_start |=> st.state == S_IDLE && !st.scl_oe)
    else $error("unmatched address was accepted");

  AST_SECOND_ADDR: assert property (
    ev_eval && st.mask[MK_SECOND] && st.shift[7:1] == st.mask[7:1] &&
    !ev_start && !ev_stop |=> st.addr_stop_flag)
    else $error("second address not matched");

  AST_BLOCKED: assert property (
    reg_wr && reg_addr == REG_DATA && !st.scl_oe && !ev_rxdone |=>
      st.data == $past(st.data))
    else $error("data written while byte in flight");

  AST_CLEAR_ON_ACCESS: assert property (
    data_access && st.scl_oe && !ev_stop |=>
      !st.data_flag && !st.addr_stop_flag ##1 !st.scl_oe)
    else $error("data access did not clear flags and hold");

  AST_RX_BYTE: assert property (
    ev_rxdone && !ev_start && !ev_stop && st.enable |=>
      st.data_flag && st.data == $past(st.shift) ##1 st.scl_oe)
    else $error("received byte did not flag and hold");

  AST_ACK_DRIVE: assert property (
    st.state == S_ACK |-> st.sda_oe == !st.nack)
    else $error("acknowledge level wrong");

  AST_SMART_READ: assert property (
    st.smart && reg_rd && reg_addr == REG_DATA && st.scl_oe &&
    st.state == S_HOLD && st.need_ack && !st.direction_status &&
    st.enable && !ev_start && !ev_stop |=> st.state == S_ACK)
    else $error("smart read did not start acknowledge");

  AST_HOLD_RELEASE: assert property (
    st.scl_oe && !(data_access || reg_wr) && !ev_start && !ev_stop &&
    st.enable |=> st.scl_oe)
    else $error("clock hold dropped without software");

  // reset is the trigger here, so the default disable must not apply
  AST_RESET_MASK: assert property (@(posedge clk_sys)
    disable iff (1'b0) rst |=> !st.mask[MK_SECOND])
    else $error("second address enabled after reset");

  COV_ADDR_MATCH: cover property (ev_eval ##1 st.addr_stop_flag);
  COV_RX_BYTE: cover property (ev_rxdone);
  COV_TX_ACK: cover property (st.state == S_TX_ACK ##1
                              st.state == S_HOLD);
  COV_STOP: cover property (ev_stop && st.stop_ie);

endmodule

// *** testbench/i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input  wire logic clk_sys,
  // slave pull enables
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // wire levels, pulled up
  output logic      scl_w,
  output logic      sda_w
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // release scl, then wait out a stretch before timing the high phase
  task automatic rise();
    int n;
    n = 0;
    scl_low <= 1'b0;
    wt(1);
    while (!scl_w && n < 3000) begin
      wt(1);
      n++;
    end
    wt(2);
    @(negedge clk_sys);
  endtask

  // sda only moves one cycle after scl fell, never while high
  task automatic bit_io(input logic b, output logic r);
    wt(1);
    sda_low <= !b;
    wt(3);
    rise();
    r = sda_w;
    wt(1);
    scl_low <= 1'b1;
  endtask

  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
  endtask

  task automatic start();
    wt(1);
    sda_low <= 1'b1;
    wt(4);
    scl_low <= 1'b1;
  endtask

  task automatic stop();
    wt(1);
    sda_low <= 1'b1;
    wt(4);
    rise();
    wt(1);
    sda_low <= 1'b0;
    wt(8);
  endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import two_wire_slave_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [7:0]            reg_rdata;
  logic                  scl_w;
  logic                  sda_w;
  logic                  scl_oe;
  logic                  sda_oe;
  logic                  irq;
  logic                  scl_o;
  logic                  sda_o;
  int                    n_fail = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  logic [7:0]            st;
  logic [7:0]            d1;
  logic [7:0]            d2;
  logic [7:0]            r;
  logic                  ak;
  logic [31:0]           c;
  // own, mask, promiscuous, address byte
  logic [31:0] tbl [0:10] = '{32'h5200_0052, 32'h5200_0053, 32'h5200_0054,
    32'h5300_0000, 32'h5200_0000, 32'hF600_00F6, 32'hF600_00F2,
    32'h5200_01A4, 32'h5206_0054, 32'h5207_0006, 32'h5207_0054};

  always #12.5 clk_sys = !clk_sys;

  two_wire_slave_addr_data dut_u (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .scl_in    (scl_w),
    .scl_out   (scl_o),
    .scl_oe    (scl_oe),
    .sda_in    (sda_w),
    .sda_out   (sda_o),
    .sda_oe    (sda_oe),
    .irq       (irq)
  );

  i2c_master_model m_u (
    .clk_sys (clk_sys),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe),
    .scl_w   (scl_w),
    .sda_w   (sda_w)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    st = reg_rdata;
    check(st & m, e);
  endtask

  // the release lands a cycle or two after the strobe
  task automatic wait_hold();
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    while (scl_oe !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  function automatic logic exp_match(input logic [31:0] k);
    logic [6:0] a;
    a = k[7:1];
    if (k[8]) return 1'b1;
    if (a == 7'h00 && k[24]) return 1'b1;
    if (k[16]) return a == k[31:25] || a == k[23:17];
    return ((a ^ k[31:25]) & ~k[23:17]) == 7'h00;
  endfunction

  initial begin
    void'($urandom(32'h9827));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(REG_OWN, 8'hFF, OWN_RESET);
    rdc(REG_MASK, 8'hFF, MASK_RESET);
    rdc(REG_STATUS, 8'hFF, 8'h00);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'hFF, 8'h00);
    rdc(REG_DATA, 8'hFF, 8'h00);
    check({6'h00, scl_o, sda_o}, 8'h00);
    wr(REG_IRQ_EN, 8'hC0);
    $display("test reset done");
    for (int i = 0; i < 19; i++) begin
      d1 = 8'($urandom);
      c = i < 11 ? tbl[i] : {d1, 5'h00, 3'($urandom_range(0, 7)), 8'h00,
        d1[7:1] ^ 7'($urandom_range(0, 3)), 1'($urandom_range(0, 1))};
      wr(REG_OWN, c[31:24]);
      wr(REG_MASK, c[23:16]);
      wr(REG_CTRL_A, {6'h03, c[8], 1'b0});
      ak = 1'($urandom_range(0, 1));
      fork
        begin
          m_u.start();
          m_u.xfer(c[7:0], r);
          m_u.bit_io(1'b1, r[0]);
        end
        if (exp_match(c)) begin
          wait_hold();
          rdc(REG_STATUS, 8'hE3, {6'h18, c[0], 1'b1});
          check({7'h00, irq}, 8'h01);
          wr(REG_IRQ_EN, 8'h00);
          @(posedge clk_sys);
          @(negedge clk_sys);
          check({7'h00, irq}, 8'h00);
          wr(REG_IRQ_EN, 8'hC0);
          wr(REG_CTRL_B, {5'h00, ak, 2'b10});
        end
      join
      check({7'h00, r[0]},
            {7'h00, ((exp_match(c) && !c[0]) ? ak : 1'b1)});
      rdc(REG_STATUS, 8'hE0, 8'h00);
      m_u.stop();
      rdc(REG_STATUS, 8'h41, 8'h40);
      wr(REG_STATUS, 8'hC0);
    end
    $display("test address match done");
    wr(REG_OWN, 8'h52);
    wr(REG_MASK, 8'h00);
    wr(REG_CTRL_A, 8'h09);
    d1 = 8'($urandom) | 8'h01;
    d2 = 8'($urandom) | 8'h01;
    fork
      begin
        m_u.start();
        m_u.xfer(8'h52, r);
        m_u.bit_io(1'b1, ak);
        check({7'h00, ak}, 8'h00);
        m_u.xfer(d1, r);
        m_u.bit_io(1'b1, ak);
        check({7'h00, ak}, 8'h00);
        m_u.xfer(d2, r);
        m_u.bit_io(1'b1, ak);
        check({7'h00, ak}, 8'h01);
      end
      begin
        wait_hold();
        wr(REG_CTRL_B, 8'h03);
        wait_hold();
        rdc(REG_STATUS, 8'hE0, 8'hA0);
        rdc(REG_DATA, 8'hFF, d1);
        rdc(REG_STATUS, 8'hE0, 8'h00);
        wait_hold();
        wr(REG_CTRL_B, 8'h04);
        rdc(REG_DATA, 8'hFF, d2);
        rdc(REG_DATA, 8'hFF, 8'h00);
      end
    join
    m_u.stop();
    wr(REG_STATUS, 8'hC0);
    $display("test master write done");
    wr(REG_CTRL_A, 8'h08);
    fork
      begin
        m_u.start();
        m_u.xfer(8'h53, r);
        m_u.bit_io(1'b1, ak);
        check({7'h00, ak}, 8'h00);
        m_u.xfer(8'hFF, r);
        check(r, d1);
        m_u.bit_io(1'b0, ak);
        m_u.xfer(8'hFF, r);
        check(r, d2);
        m_u.bit_io(1'b1, ak);
      end
      begin
        wait_hold();
        wr(REG_CTRL_B, 8'h03);
        wait_hold();
        wr(REG_DATA, d1);
        rdc(REG_STATUS, 8'hE0, 8'h00);
        wait_hold();
        rdc(REG_STATUS, 8'hF2, 8'hA2);
        wr(REG_DATA, d2);
        wait_hold();
        rdc(REG_STATUS, 8'hF0, 8'hB0);
        wr(REG_STATUS, 8'h80);
      end
    join
    m_u.stop();
    $display("test master read done");
    final_report();
  end
endmodule
